// File: logic/gpio_port_pin_config_io.sv
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_pin_config_io #(
  parameter int NPINS = 16
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o,
  // pads
  input  wire logic [NPINS-1:0] pad_in_i,
  output logic      [NPINS-1:0] pad_out_o,
  output logic      [NPINS-1:0] pad_oe_o,
  // pin configuration for pins 8..15
  output logic      [31:0]      pin_config_upper_o
);
  // number of pins covered by the upper config register
  localparam int    NUP = NPINS - `UPPER_FIRST_PIN;

  logic [31:0]      cfg_upper_r;
  logic [15:0]      out_level_r;
  logic [NPINS-1:0] in_sync;
  logic             req;
  logic             hit_cfg;
  logic             hit_in;
  logic             hit_out;
  logic [NUP-1:0]   gp_out;
  logic [NUP-1:0]   drive_en;
  logic [NUP-1:0]   drive_lvl;

  pin_sync #(.W(NPINS)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (pad_in_i),
    .sync_o    (in_sync)
  );

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit_cfg = wb_adr_i == `CFG_UPPER_OFFSET;
  assign hit_in  = wb_adr_i == `IN_LEVEL_OFFSET;
  assign hit_out = wb_adr_i == `OUT_LEVEL_OFFSET;

  // upper config register, byte lanes honoured
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_upper_r <= `CFG_UPPER_RESET;
    end else if (req && wb_we_i && hit_cfg) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          cfg_upper_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // output level register, word writes only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_level_r <= `OUT_LEVEL_RESET;
    end else if (req && wb_we_i && hit_out && wb_sel_i == 4'hF) begin
      out_level_r <= wb_dat_i[15:0];
    end
  end

  // bus answer: one cycle after request, unmapped gives err
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req && (hit_cfg || hit_in || hit_out);
      wb_err_o <= req && !(hit_cfg || hit_in || hit_out);
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        if (hit_cfg) begin
          wb_dat_o <= cfg_upper_r;
        end else if (hit_in) begin
          wb_dat_o <= {16'h0000, in_sync[15:0]};
        end else if (hit_out) begin
          wb_dat_o <= {16'h0000, out_level_r};
        end
      end
    end
  end

  // pad drive decision per upper pin
  genvar g;
  generate
    for (g = 0; g < NUP; g++) begin : g_upper
      logic [1:0] mode_f;
      logic [1:0] cfg_f;
      assign mode_f       = cfg_upper_r[g*`NIBBLE_W + `FIELD_MODE_LSB +: 2];
      assign cfg_f        = cfg_upper_r[g*`NIBBLE_W + `FIELD_CFG_LSB +: 2];
      // alternate configs leave the pad to a source outside this block
      assign gp_out[g]    = (mode_f != gpio_port_pkg::MODE_INPUT) && !cfg_f[1];
      // open drain drives only a low level
      assign drive_en[g]  = gp_out[g] && (!cfg_f[0] || !out_level_r[`UPPER_FIRST_PIN + g]);
      assign drive_lvl[g] = gp_out[g] && out_level_r[`UPPER_FIRST_PIN + g];
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o          <= '0;
      pad_oe_o           <= '0;
      pin_config_upper_o <= `CFG_UPPER_RESET;
    end else begin
      pin_config_upper_o <= cfg_upper_r;
      // lower pins belong to the lower config register, kept idle here
      pad_oe_o           <= {drive_en, {`UPPER_FIRST_PIN{1'b0}}};
      pad_out_o          <= {drive_lvl, {`UPPER_FIRST_PIN{1'b0}}};
    end
  end

  property p_od_low;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg_upper_r[1:0] != 2'h0 && cfg_upper_r[3:2] == 2'h1 && !out_level_r[8] |=> pad_oe_o[8] && !pad_out_o[8];
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain pin not pulling low");

  property p_od_release;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg_upper_r[1:0] != 2'h0 && cfg_upper_r[3:2] == 2'h1 && out_level_r[8] |=> !pad_oe_o[8];
  endproperty
  a_od_release: assert property (p_od_release)
    else $error("open-drain pin driving high");

  sequence s_read_out;
    req && !wb_we_i && hit_out;
  endsequence
  property p_out_read;
    @(posedge ref_clk_i) disable iff (rst_i) s_read_out |=> wb_dat_o == {16'h0000, $past(out_level_r)};
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("output level readback mismatch");

  property p_ack_pulse;
    @(posedge ref_clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  sequence s_read_in;
    req && !wb_we_i && hit_in;
  endsequence
  property p_in_upper_zero;
    @(posedge ref_clk_i) disable iff (rst_i) s_read_in |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_in_upper_zero: assert property (p_in_upper_zero)
    else $error("input level upper half not zero");

  property p_in_follow;
    @(posedge ref_clk_i) disable iff (rst_i) s_read_in |=> wb_dat_o[15:0] == $past(in_sync[15:0]);
  endproperty
  a_in_follow: assert property (p_in_follow)
    else $error("input level read mismatch");

  property p_cfg_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      req && wb_we_i && hit_cfg && wb_sel_i == 4'hF |=> cfg_upper_r == $past(wb_dat_i);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write lost");

  property p_out_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      req && wb_we_i && hit_out && wb_sel_i == 4'hF |=> out_level_r == $past(wb_dat_i[15:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output level write lost");

  property p_out_partial;
    @(posedge ref_clk_i) disable iff (rst_i)
      req && wb_we_i && hit_out && wb_sel_i != 4'hF |=> $stable(out_level_r);
  endproperty
  a_out_partial: assert property (p_out_partial)
    else $error("partial write changed output level");

  property p_input_no_drive;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg_upper_r[29:28] == 2'h0 |=> !pad_oe_o[15];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input-mode pin driven");

  property p_pp_drive;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg_upper_r[1:0] != 2'h0 && cfg_upper_r[3:2] == 2'h0 |=> pad_oe_o[8] && pad_out_o[8] == $past(out_level_r[8]);
  endproperty
  a_pp_drive: assert property (p_pp_drive)
    else $error("push-pull pin not driving level");

  property p_af_no_drive;
    @(posedge ref_clk_i) disable iff (rst_i) cfg_upper_r[3] |=> !pad_oe_o[8];
  endproperty
  a_af_no_drive: assert property (p_af_no_drive)
    else $error("alternate config pin driven by output bit");

  property p_cfg_read;
    @(posedge ref_clk_i) disable iff (rst_i)
      req && !wb_we_i && hit_cfg |=> wb_dat_o == $past(cfg_upper_r);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config readback mismatch");
endmodule

// File: logic/gpio_port_pkg.sv
package gpio_port_pkg;
  typedef enum logic [1:0] {
    MODE_INPUT   = 2'h0,
    MODE_OUT_10M = 2'h1,
    MODE_OUT_2M  = 2'h2,
    MODE_OUT_50M = 2'h3
  } mode_e;
  typedef enum logic [1:0] {
    CFG_OUT_PP_GP = 2'h0,
    CFG_OUT_OD_GP = 2'h1,
    CFG_OUT_PP_AF = 2'h2,
    CFG_OUT_OD_AF = 2'h3
  } out_cfg_e;
  typedef enum logic [1:0] {
    CFG_IN_ANALOG   = 2'h0,
    CFG_IN_FLOATING = 2'h1,
    CFG_IN_PULL     = 2'h2,
    CFG_IN_RESERVED = 2'h3
  } in_cfg_e;
endpackage

// File: logic/gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH
`define CFG_UPPER_OFFSET  8'h04
`define IN_LEVEL_OFFSET   8'h08
`define OUT_LEVEL_OFFSET  8'h0C
`define CFG_UPPER_RESET   32'h44444444
`define OUT_LEVEL_RESET   16'h0000
`define FIELD_MODE_LSB    0
`define FIELD_CFG_LSB     2
`define NIBBLE_W          4
`define UPPER_FIRST_PIN   8
`endif

// File: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// File: tb/pad_model.sv
`timescale 1ns/1ps
module pad_model (
  // pads
  input  wire logic [15:0] pad_out_i,
  input  wire logic [15:0] pad_oe_i,
  input  wire logic [15:0] ext_i,
  output logic      [15:0] pad_in_o
);
  // driven pins read back their own level, others the outside level
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc       = 1'b0;
  logic        we        = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [3:0]  sel       = 4'hF;
  logic [31:0] wdat      = 32'h00000000;
  logic [15:0] ext       = 16'h0000;
  logic [31:0] dat_o, cfg_o, rd;
  logic        ack, err, got_err;
  logic [15:0] pin_in, pout, poe;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [71:0] rows [4] = '{{8'h04, 32'hA5A5A5A5, 32'hA5A5A5A5}, {8'h04, 32'h5A5A5A5A, 32'h5A5A5A5A},
                            {8'h0C, 32'h0000FFFF, 32'h0000FFFF}, {8'h0C, 32'h00001234, 32'h00001234}};

  gpio_port_pin_config_io dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .pad_in_i(pin_in), .pad_out_o(pout), .pad_oe_o(poe), .pin_config_upper_o(cfg_o));
  pad_model pads (.pad_out_i(pout), .pad_oe_i(poe), .ext_i(ext), .pad_in_o(pin_in));

  always #5 ref_clk_i = ~ref_clk_i;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    rd = dat_o;
    got_err = err;
    if (i == 20) n_mismatch++;
    cyc <= 1'b0;
  endtask

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 8'h04, 4'hF, 32'h0);
    chk("cfg reset", 32'h44444444, rd);
    chk("cfg out reset", 32'h44444444, cfg_o);
    xfer(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("level reset", 32'h00000000, rd);
    ext <= 16'hA55A;
    repeat (5) @(posedge ref_clk_i);
    xfer(1'b1, 8'h08, 4'hF, 32'h0000FFFF);
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("input", 32'h0000A55A, rd);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, rows[k][71:64], 4'hF, rows[k][63:32]);
      xfer(1'b0, rows[k][71:64], 4'hF, 32'h0);
      chk("row", rows[k][31:0], rd);
    end
    xfer(1'b1, 8'h04, 4'h1, 32'h000000FF);
    xfer(1'b0, 8'h04, 4'hF, 32'h0);
    chk("cfg byte", 32'h5A5A5AFF, rd);
    xfer(1'b1, 8'h0C, 4'h3, 32'h0000FFFF);
    xfer(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("level part", 32'h00001234, rd);
    xfer(1'b0, 8'h20, 4'hF, 32'h0);
    chk("unmapped", 32'h1, 32'(got_err));
    xfer(1'b1, 8'h0C, 4'hF, 32'h0000FF00);
    for (int m = 0; m < 16; m++) begin
      xfer(1'b1, 8'h04, 4'hF, {28'h4444444, 4'(m)});
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("oe8", 32'(m[1:0] != 0 && m[3:2] == 0), 32'(poe[8]));
      chk("out8", 32'(m[1:0] != 0 && m[3] == 0), 32'(pout[8]));
      chk("cfg out", {28'h4444444, 4'(m)}, cfg_o);
    end
    chk("oe low pins", 32'h0, 32'(poe[7:0]));
    xfer(1'b1, 8'h0C, 4'hF, 32'h00000000);
    xfer(1'b1, 8'h04, 4'hF, 32'h44444445);
    repeat (5) @(posedge ref_clk_i);
    #1;
    chk("od low oe8", 32'h1, 32'(poe[8]));
    chk("od low out8", 32'h0, 32'(pout[8]));
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("input loopback", 32'h0000A45A, rd);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 8'h04, 4'hF, 32'h0);
    chk("cfg rereset", 32'h44444444, rd);
    xfer(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("level rereset", 32'h00000000, rd);
    chk("oe rereset", 32'h0, 32'(poe));
    chk("out rereset", 32'h0, 32'(pout));
    complete_run();
  end
endmodule
